// ==== logic/bps_pkg.sv ====
/*
 * constants, register map and state type of the boot select and power signal block.
 * assumes a 10 MHz reference clock; slow timing counts run on a 32 kHz suspend tick.
 */
package bps_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // clocking and timing
   localparam int unsigned REF_HZ = 10_000_000;
   localparam int unsigned SUSCLK_HZ = 32_000;
   localparam int unsigned SUS_HALF_CYCLES = REF_HZ / (2 * SUSCLK_HZ);
   localparam int unsigned DEBOUNCE_MS = 16;
   localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS * SUSCLK_HZ / 1000;
   localparam int unsigned RSTHOLD_MS = 5;
   localparam int unsigned RSTHOLD_TICKS = (RSTHOLD_MS * SUSCLK_HZ + 999) / 1000;
   localparam int unsigned OVERRIDE_S = 4;
   localparam int unsigned OVERRIDE_TICKS = OVERRIDE_S * SUSCLK_HZ;
   localparam int unsigned SUS_PREP_TICKS = 2;
   localparam int unsigned TICK_W = 17;
   localparam int unsigned DIV_W = 9;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RSTCTL = 8'h04;
   localparam logic [7:0] OFS_SLEEP = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;

   // control, reset control and sleep register fields
   localparam int unsigned CTRL_TS_BIT = 0;
   localparam int unsigned CTRL_LOCK_BIT = 1;
   localparam int unsigned CTRL_BBSZ_LSB = 2;
   localparam int unsigned CTRL_SCI_EN_BIT = 4;
   localparam int unsigned CTRL_BATSMI_EN_BIT = 5;
   localparam int unsigned CTRL_PWRBTN_EN_BIT = 6;
   localparam int unsigned RSTCTL_HARD_BIT = 1;
   localparam int unsigned SLEEP_TYPE_LSB = 0;
   localparam int unsigned SLEEP_GO_BIT = 2;

   // status register fields
   localparam int unsigned STS_PWRBTN_BIT = 0;
   localparam int unsigned STS_BATLOW_BIT = 1;

   // reset values
   localparam logic [1:0] BBSZ_RESET = 2'h0;
   localparam logic EN_RESET = 1'b0;
   localparam logic BBS_STRAP_RESET = 1'b1;

   // sleep type codes and boot address
   localparam logic [1:0] SLP_TYPE_S3 = 2'h1;
   localparam logic [1:0] SLP_TYPE_S4 = 2'h2;
   localparam logic [1:0] SLP_TYPE_S5 = 2'h3;
   localparam int unsigned BOOT_ADDR_LSB = 16;

   typedef enum logic [2:0] {BPS_S0, BPS_PREP, BPS_S3, BPS_S4, BPS_S5} bps_state_type;

endpackage

// ==== logic/bps_debounce.sv ====
/*
 * two-flop synchroniser and tick-counted debounce filter for one active-low button pin.
 * assumes tick_i is a one-cycle enable from the suspend clock divider.
 */
`timescale 1ns/100ps
module bps_debounce #(
   parameter int unsigned TICKS = bps_pkg::DEBOUNCE_TICKS
) (
   input wire logic ref_clk_i,  // reference clock
   input wire logic reset_i,    // synchronous reset
   input wire logic tick_i,     // suspend clock tick
   input wire logic pin_n_i,    // raw button pin, low when pressed
   output logic pressed_o,      // filtered level, high when pressed
   output logic press_o         // one-cycle pulse on a filtered press
);

   logic meta_q;
   logic sync_q;
   logic level_q;
   logic press_q;
   logic [bps_pkg::TICK_W-1:0] cnt_q;
   wire differ = sync_q != level_q;
   wire settled = differ && tick_i && (cnt_q == bps_pkg::TICK_W'(TICKS - 1));

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= ~pin_n_i;
         sync_q <= meta_q;
      end
   end

   // counter restarts whenever the input agrees with the filtered level
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !differ) begin
         cnt_q <= '0;
      end else if (tick_i) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         level_q <= 1'b0;
         press_q <= 1'b0;
      end else begin
         level_q <= settled ? sync_q : level_q;
         press_q <= settled && sync_q;
      end
   end

   assign pressed_o = level_q;
   assign press_o = press_q;

endmodule // bps_debounce

// ==== logic/bps_boot_power.sv ====
/*
 * boot source selection, top-swap address redirection and power management pins.
 * assumes reset_i is the resume-well reset and rtc_reset_i clears only the always-on well.
 */
// Strobed register access and the register addresses are this design's own decisions.
// Overview of operation
// R1: top-swap inverts one fetch address bit chosen by boot block size.
// R2: while top-swap is active all boot fetches go to the secondary sector.
// R3: software top-swap bit lives in the always-on well, survives power-down.
// R4: top-swap bit writes are ignored once the boot lock bit is set.
// R5: active-low top-swap strap sampled at power-up activates top-swap.
// R6: asserted strap forces top-swap without changing the stored bit.
// R7: strap asserted keeps the top-swap bit unchangeable until next deasserted power-up.
// R8: boot-source strap low selects low-pin-count bus, high selects serial flash.
// R9: secure boot forbids booting from the low-pin-count bus.
// R10: platform reset asserted at power-up and on software hard reset.
// R11: power button press in working state raises management or ACPI interrupt.
// R12: power button press during sleep is a wake event.
// R13: button held past override time forces soft-off.
// R14: power button is debounced before any action.
// R15: debounced reset button forces an internal reset.
// R16: S4 plane control asserted in S4 or S5.
// R17: S3 plane control asserted in S3, S4 or S5.
// R18: suspend status asserted ahead of entering a low-power state; the override path enters S5 with no step ahead of it.
// R19: continuous suspend clock output from the slow oscillator divider; here it is divided from the 10 MHz reference clock.
// R20: suspend power-down acknowledge asserted when suspend well is not needed.
// R21: battery low can raise a management interrupt.
// R22: reset-button reset is held for its full duration regardless of button.
// R23: override timer counts only in the working state.
// R24: timing counts suspend ticks; counters restart when button deasserts.
// R25: straps captured once after resume reset release and held.
`timescale 1ns/100ps
module bps_boot_power #(
   parameter int unsigned ADDR_W = 32,
   parameter int unsigned SUS_HALF = bps_pkg::SUS_HALF_CYCLES,
   parameter int unsigned DEB_TICKS = bps_pkg::DEBOUNCE_TICKS,
   parameter int unsigned HOLD_TICKS = bps_pkg::RSTHOLD_TICKS,
   parameter int unsigned OVR_TICKS = bps_pkg::OVERRIDE_TICKS,
   parameter int unsigned PREP_TICKS = bps_pkg::SUS_PREP_TICKS
) (
   input wire logic ref_clk_i,                // 10 MHz clock
   input wire logic reset_i,                  // resume-well reset, sync high
   input wire logic rtc_reset_i,              // always-on well reset, sync high
   input wire logic [7:0] reg_addr_i,         // register byte address
   input wire logic [31:0] reg_wdata_i,       // register write data
   input wire logic reg_wr_i,                 // write strobe
   input wire logic reg_rd_i,                 // read strobe
   output logic [31:0] reg_rdata_o,           // read data, cycle after strobe
   input wire logic secure_boot_i,            // secure boot enabled
   input wire logic boot_fetch_i,             // current fetch is boot code
   input wire logic [ADDR_W-1:0] fetch_addr_i, // processor fetch address
   output logic [ADDR_W-1:0] fetch_addr_o,    // redirected fetch address
   output logic boot_from_spi_o,              // boot from serial flash
   input wire logic suspend_gpio_two_n_i,     // top-swap strap pin, low active
   input wire logic suspend_gpio_four_i,      // boot-source strap pin
   input wire logic power_button_n_i,         // power button pin
   input wire logic reset_button_n_i,         // reset button pin
   input wire logic battery_low_n_i,          // battery low pin
   input wire logic mains_present_i,          // mains power present pin
   output logic platform_reset_n_o,           // platform reset
   output logic internal_reset_o,             // internal reset request
   output logic sleep_plane4_ctrl_n_o,        // S4 plane control
   output logic sleep_plane3_ctrl_n_o,        // S3 plane control
   output logic suspend_status_n_o,           // suspend status
   output logic suspend_clock_out_o,          // suspend clock
   output logic suspend_powerdown_ack_o,      // suspend power-down acknowledge
   output logic mgmt_interrupt_n_o,           // management interrupt, low active
   output logic acpi_event_interrupt_o        // ACPI event interrupt
);

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [3:0] pin_m_q;
   logic [3:0] pin_s_q;
   logic [1:0] cap_cnt_q;
   logic ts_strap_q;
   logic bbs_strap_q;
   logic ts_bit_q;
   logic lock_q;
   logic [1:0] bbsz_q;
   logic sci_en_q;
   logic batsmi_en_q;
   logic pwrbtn_en_q;
   logic [ADDR_W-1:0] fetch_addr_q;
   logic [bps_pkg::DIV_W-1:0] div_q;
   logic susclk_q;
   logic [bps_pkg::TICK_W-1:0] ovr_q;
   logic [bps_pkg::TICK_W-1:0] hold_q;
   logic hold_act_q;
   logic armed_q;
   logic [1:0] prep_q;
   logic [1:0] slp_tgt_q;
   bps_pkg::bps_state_type state_q;
   bps_pkg::bps_state_type state_d;
   logic pwrbtn_sts_q;
   logic batlow_sts_q;
   logic bat_lvl_q;
   logic pltrst_n_q;
   logic smi_n_q;
   logic sci_q;
   logic [31:0] rdata_q;
   logic pb_lvl;
   logic pb_press;
   logic rb_lvl;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // decode
   wire wr_ctrl = reg_wr_i && (reg_addr_i == bps_pkg::OFS_CTRL);
   wire wr_rst = reg_wr_i && (reg_addr_i == bps_pkg::OFS_RSTCTL);
   wire wr_sleep = reg_wr_i && (reg_addr_i == bps_pkg::OFS_SLEEP);
   wire wr_status = reg_wr_i && (reg_addr_i == bps_pkg::OFS_STATUS);
   wire cap_done = cap_cnt_q == 2'h3;
   wire cap_now = cap_cnt_q == 2'h2;
   wire ts_wr = wr_ctrl && cap_done && !lock_q && !ts_strap_q;
   wire ts_active = ts_bit_q || ts_strap_q;
   wire [1:0] bbsz_sel = (bbsz_q == 2'h3) ? 2'h2 : bbsz_q;
   wire [ADDR_W-1:0] flip_mask = ADDR_W'(1) << (bps_pkg::BOOT_ADDR_LSB + 32'(bbsz_sel));
   wire tick = !susclk_q && (div_q == bps_pkg::DIV_W'(SUS_HALF - 1));
   wire in_s0 = state_q == bps_pkg::BPS_S0;
   wire asleep = (state_q == bps_pkg::BPS_S3) || (state_q == bps_pkg::BPS_S4) || (state_q == bps_pkg::BPS_S5);
   wire ovr_hit = in_s0 && pb_lvl && tick && (ovr_q == bps_pkg::TICK_W'(OVR_TICKS - 1));
   wire prep_done = tick && (prep_q == 2'(PREP_TICKS - 1));
   wire hard_req = wr_rst && reg_wdata_i[bps_pkg::RSTCTL_HARD_BIT];
   wire btn_req = rb_lvl && armed_q && !hold_act_q;
   wire hold_end = hold_act_q && tick && (hold_q == bps_pkg::TICK_W'(HOLD_TICKS - 1));
   wire sleep_go = wr_sleep && reg_wdata_i[bps_pkg::SLEEP_GO_BIT] && (reg_wdata_i[1:0] != 2'h0);
   wire bat_lvl = !pin_s_q[2];
   wire pwrbtn_set = in_s0 && pb_press;
   wire batlow_set = bat_lvl && !bat_lvl_q;
   wire pwrbtn_clr = wr_status && reg_wdata_i[bps_pkg::STS_PWRBTN_BIT];
   wire batlow_clr = wr_status && reg_wdata_i[bps_pkg::STS_BATLOW_BIT];
   wire [31:0] ctrl_rd = {25'h0, pwrbtn_en_q, batsmi_en_q, sci_en_q, bbsz_q, lock_q, ts_bit_q};
   wire [31:0] sleep_rd = {30'h0, slp_tgt_q};
   wire [31:0] status_rd = {20'h0, pin_s_q[3], internal_reset_o, state_q, boot_from_spi_o, bbs_strap_q,
                            ts_strap_q, ts_active, pb_lvl, batlow_sts_q, pwrbtn_sts_q};
   wire [31:0] rd_mux = (reg_addr_i == bps_pkg::OFS_CTRL) ? ctrl_rd :
                        (reg_addr_i == bps_pkg::OFS_SLEEP) ? sleep_rd :
                        (reg_addr_i == bps_pkg::OFS_STATUS) ? status_rd : 32'h0;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and strap capture
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         // idle pin levels, so no false battery-low edge follows reset
         pin_m_q <= 4'h5;
         pin_s_q <= 4'h5;
      end else begin
         pin_m_q <= {mains_present_i, battery_low_n_i, suspend_gpio_four_i, suspend_gpio_two_n_i};
         pin_s_q <= pin_m_q;
      end
   end

   // straps are caught once the synchronisers hold post-release pin levels
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         cap_cnt_q <= 2'h0;
         ts_strap_q <= 1'b0;
         bbs_strap_q <= bps_pkg::BBS_STRAP_RESET;
      end else if (!cap_done) begin
         cap_cnt_q <= cap_cnt_q + 2'h1;
         if (cap_now) begin
            ts_strap_q <= !pin_s_q[0]; // R5 R25
            bbs_strap_q <= pin_s_q[1]; // R25
         end
      end
   end

   assign boot_from_spi_o = bbs_strap_q || secure_boot_i; // R8 R9

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // boot control and top swap
   always_ff @(posedge ref_clk_i) begin
      if (rtc_reset_i) begin
         ts_bit_q <= 1'b0;
      end else if (ts_wr) begin
         ts_bit_q <= reg_wdata_i[bps_pkg::CTRL_TS_BIT]; // R3 R4 R7
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         lock_q <= 1'b0;
         bbsz_q <= bps_pkg::BBSZ_RESET;
         sci_en_q <= bps_pkg::EN_RESET;
         batsmi_en_q <= bps_pkg::EN_RESET;
         pwrbtn_en_q <= bps_pkg::EN_RESET;
      end else if (wr_ctrl) begin
         lock_q <= lock_q || reg_wdata_i[bps_pkg::CTRL_LOCK_BIT];
         bbsz_q <= reg_wdata_i[bps_pkg::CTRL_BBSZ_LSB +: 2];
         sci_en_q <= reg_wdata_i[bps_pkg::CTRL_SCI_EN_BIT];
         batsmi_en_q <= reg_wdata_i[bps_pkg::CTRL_BATSMI_EN_BIT];
         pwrbtn_en_q <= reg_wdata_i[bps_pkg::CTRL_PWRBTN_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         fetch_addr_q <= '0;
      end else begin
         fetch_addr_q <= (boot_fetch_i && ts_active) ? (fetch_addr_i ^ flip_mask) : fetch_addr_i; // R1 R2 R6
      end
   end

   assign fetch_addr_o = fetch_addr_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // suspend clock divider, one tick per suspend clock period
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         div_q <= '0;
         susclk_q <= 1'b0;
      end else if (div_q == bps_pkg::DIV_W'(SUS_HALF - 1)) begin
         div_q <= '0;
         susclk_q <= !susclk_q; // R19
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   assign suspend_clock_out_o = susclk_q;

   bps_debounce #(
      .TICKS(DEB_TICKS)
   ) u_pwr_btn (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .tick_i(tick),
      .pin_n_i(power_button_n_i),
      .pressed_o(pb_lvl),
      .press_o(pb_press)
   ); // R14

   bps_debounce #(
      .TICKS(DEB_TICKS)
   ) u_rst_btn (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .tick_i(tick),
      .pin_n_i(reset_button_n_i),
      .pressed_o(rb_lvl),
      .press_o()
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // power button override timer
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || !pb_lvl || !in_s0) begin
         ovr_q <= '0; // R23 R24
      end else if (tick) begin
         ovr_q <= ovr_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // sleep state machine
   always_comb begin
      state_d = state_q;
      case (state_q)
         bps_pkg::BPS_S0: begin
            if (ovr_hit) begin
               state_d = bps_pkg::BPS_S5; // R13
            end else if (sleep_go) begin
               state_d = bps_pkg::BPS_PREP;
            end
         end
         bps_pkg::BPS_PREP: begin
            if (prep_done) begin
               case (slp_tgt_q)
                  bps_pkg::SLP_TYPE_S3: state_d = bps_pkg::BPS_S3;
                  bps_pkg::SLP_TYPE_S4: state_d = bps_pkg::BPS_S4;
                  default: state_d = bps_pkg::BPS_S5;
               endcase
            end
         end
         bps_pkg::BPS_S3, bps_pkg::BPS_S4, bps_pkg::BPS_S5: begin
            if (pb_press) begin
               state_d = bps_pkg::BPS_S0; // R12
            end
         end
         default: state_d = bps_pkg::BPS_S0;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_q <= bps_pkg::BPS_S0;
         slp_tgt_q <= 2'h0;
         prep_q <= 2'h0;
      end else begin
         state_q <= state_d;
         slp_tgt_q <= (in_s0 && sleep_go) ? reg_wdata_i[bps_pkg::SLEEP_TYPE_LSB +: 2] : slp_tgt_q;
         prep_q <= (state_q != bps_pkg::BPS_PREP) ? 2'h0 : (tick ? prep_q + 2'h1 : prep_q);
      end
   end

   assign sleep_plane4_ctrl_n_o = !((state_q == bps_pkg::BPS_S4) || (state_q == bps_pkg::BPS_S5)); // R16
   assign sleep_plane3_ctrl_n_o = !asleep; // R17
   assign suspend_status_n_o = !(asleep || (state_q == bps_pkg::BPS_PREP)); // R18
   assign suspend_powerdown_ack_o = state_q == bps_pkg::BPS_S5; // R20

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // reset hold: power-up, software hard reset and reset button
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         hold_act_q <= 1'b1; // R10
         hold_q <= '0;
         armed_q <= 1'b1;
      end else begin
         if (btn_req || hard_req) begin
            hold_act_q <= 1'b1; // R10 R15
            hold_q <= '0;
         end else if (hold_end) begin
            hold_act_q <= 1'b0;
         end else if (hold_act_q && tick) begin
            hold_q <= hold_q + 1'b1; // R22
         end
         if (btn_req) begin
            armed_q <= 1'b0;
         end else if (!rb_lvl && in_s0 && pltrst_n_q) begin
            armed_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pltrst_n_q <= 1'b0;
      end else begin
         pltrst_n_q <= in_s0 && !hold_act_q; // R10
      end
   end

   assign platform_reset_n_o = pltrst_n_q;
   assign internal_reset_o = hold_act_q; // R15 R22

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // event status and interrupt outputs
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pwrbtn_sts_q <= 1'b0;
         batlow_sts_q <= 1'b0;
         bat_lvl_q <= 1'b0;
         smi_n_q <= 1'b1;
         sci_q <= 1'b0;
      end else begin
         pwrbtn_sts_q <= pwrbtn_set || (pwrbtn_sts_q && !pwrbtn_clr); // R11
         batlow_sts_q <= batlow_set || (batlow_sts_q && !batlow_clr); // R21
         bat_lvl_q <= bat_lvl;
         smi_n_q <= !((pwrbtn_sts_q && pwrbtn_en_q && !sci_en_q) || (batlow_sts_q && batsmi_en_q)); // R11 R21
         sci_q <= pwrbtn_sts_q && pwrbtn_en_q && sci_en_q; // R11
      end
   end

   assign mgmt_interrupt_n_o = smi_n_q;
   assign acpi_event_interrupt_o = sci_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // register read port
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= reg_rd_i ? rd_mux : 32'h0;
      end
   end

   assign reg_rdata_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // checks
   a_swap_redirect: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R2
      (boot_fetch_i && ts_active) |=> (fetch_addr_o == ($past(fetch_addr_i) ^ $past(flip_mask))))
      else $error("boot fetch not redirected under top swap");

   a_ts_lock_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i || rtc_reset_i) // R4
      (wr_ctrl && lock_q) |=> $stable(ts_bit_q))
      else $error("top swap bit changed while locked");

   a_strap_freeze: assert property (@(posedge ref_clk_i) disable iff (reset_i || rtc_reset_i) // R7
      (wr_ctrl && ts_strap_q) |=> (ts_bit_q == $past(ts_bit_q)))
      else $error("top swap bit changed under strap");

   a_strap_force: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
      (ts_strap_q && boot_fetch_i) |=> (fetch_addr_o != $past(fetch_addr_i)))
      else $error("strap did not force top swap");

   a_boot_source: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R9
      (secure_boot_i || bbs_strap_q) |-> boot_from_spi_o)
      else $error("low pin count boot allowed");

   a_plane3_ctrl: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R17
      (state_q == bps_pkg::BPS_PREP) ##1 (state_q == bps_pkg::BPS_S3)
         |-> !sleep_plane3_ctrl_n_o && sleep_plane4_ctrl_n_o)
      else $error("S3 plane control wrong");

   a_plane4_ctrl: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
      ovr_hit |=> !sleep_plane4_ctrl_n_o && !sleep_plane3_ctrl_n_o && !suspend_powerdown_ack_o == 1'b0)
      else $error("override did not reach soft off");

   a_sleep_wake: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R12
      (asleep && pb_press) |=> in_s0 ##1 sleep_plane3_ctrl_n_o)
      else $error("power button did not wake");

   a_rst_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R22
      $rose(internal_reset_o) |-> internal_reset_o[*8] ##1 !platform_reset_n_o)
      else $error("reset hold released early");

   a_sus_status: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R18
      (in_s0 && sleep_go && !ovr_hit) |=> !suspend_status_n_o && sleep_plane3_ctrl_n_o)
      else $error("suspend status not ahead of sleep");

   a_pwrbtn_event: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R11
      (pwrbtn_set && pwrbtn_en_q && !pwrbtn_clr) |=> ##1 (!mgmt_interrupt_n_o || acpi_event_interrupt_o))
      else $error("power button raised no interrupt");

endmodule // bps_boot_power

// ==== verification/bps_board.sv ====
/* board model: power button, reset button and battery sense, all with pull-ups.
   assumes the bench sets the press levels just after a clock edge. */
`timescale 1ns/100ps
module bps_board (
   input wire logic pwr_press_i,   // power button held
   input wire logic rst_press_i,   // reset button held
   input wire logic bat_low_i,     // battery low
   output logic power_button_n_o,  // power button pin
   output logic reset_button_n_o,  // reset button pin
   output logic battery_low_n_o    // battery low pin
);
   // a released contact goes to its pull-up level
   assign power_button_n_o = !pwr_press_i;
   assign reset_button_n_o = !rst_press_i;
   assign battery_low_n_o = !bat_low_i;
endmodule // bps_board

// ==== verification/bps_boot_power_bench.sv ====
/* bench for bps_boot_power: straps, top swap, buttons, sleep planes.
   assumes shortened tick counts: 8 cycles a tick. */
`timescale 1ns/100ps
module bps_boot_power_bench;
   logic clk = 0, rst = 1, rtc = 0, wr = 0, rd = 0, sb = 0, bf = 0, ts_n = 1, boot_source_strap = 0, pp = 0, rp = 0, bl = 0;
   logic [7:0] ad = 8'h00;
   logic [31:0] wd = 32'h0, fa = 32'h0, rdv, fo, x;
   logic spi, prn, irst, p4, p3, ss, sck, ack, smi_n, acpi_event_interrupt, pb_n, rb_n, bl_n;
   logic [15:0] lf = 16'h0054;
   int err_total = 0, cmp_count = 0, cyc = 0, n;
   always #50 clk = !clk;
   bps_board i_bps_board (.pwr_press_i(pp), .rst_press_i(rp), .bat_low_i(bl), .power_button_n_o(pb_n),
      .reset_button_n_o(rb_n), .battery_low_n_o(bl_n));
   bps_boot_power #(.SUS_HALF(4), .DEB_TICKS(3), .HOLD_TICKS(10), .OVR_TICKS(20)) i_bps_boot_power (
      .ref_clk_i(clk), .reset_i(rst), .rtc_reset_i(rtc), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdv), .secure_boot_i(sb), .boot_fetch_i(bf), .fetch_addr_i(fa),
      .fetch_addr_o(fo), .boot_from_spi_o(spi), .suspend_gpio_two_n_i(ts_n), .suspend_gpio_four_i(boot_source_strap),
      .power_button_n_i(pb_n), .reset_button_n_i(rb_n), .battery_low_n_i(bl_n), .mains_present_i(lf[0]),
      .platform_reset_n_o(prn), .internal_reset_o(irst), .sleep_plane4_ctrl_n_o(p4),
      .sleep_plane3_ctrl_n_o(p3), .suspend_status_n_o(ss), .suspend_clock_out_o(sck),
      .suspend_powerdown_ack_o(ack), .mgmt_interrupt_n_o(smi_n), .acpi_event_interrupt_o(acpi_event_interrupt));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string s, logic [31:0] v, logic [31:0] e);
      cmp_count++;
      if (v !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", s, e, v);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [15:0] lfsr(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [31:0] swp(logic [31:0] a, logic [1:0] sz);
      return a ^ (32'h1 << (16 + (sz > 2'h2 ? 2 : sz)));
   endfunction
   task automatic wreg(logic [7:0] a, logic [31:0] d);
      @(posedge clk) begin ad <= a; wd <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a);
      @(posedge clk) begin ad <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 x = rdv;
   endtask
   task automatic fetch(logic f, logic [1:0] sz, logic t);
      @(posedge clk) begin lf <= lfsr(lf); fa <= {2{lfsr(lf)}}; bf <= f; end
      @(posedge clk) #1 chk("fetch", fo, (t & f) ? swp(fa, sz) : fa);
   endtask
   task automatic boot(logic t_n, logic b);
      @(posedge clk) begin rst <= 1'b1; ts_n <= t_n; boot_source_strap <= b; end
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 chk("plat rst", prn, 0);
      for (n = 0; n < 900 && prn !== 1'b1; n++) @(posedge clk) #1;
   endtask
   // press longer than the debounce filter needs
   task automatic press;
      @(posedge clk) pp <= 1'b1;
      repeat (64) @(posedge clk);
      pp <= 1'b0;
      repeat (40) @(posedge clk) #1;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         report_and_stop;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      boot(1'b1, 1'b0);
      chk("spi", spi, 0);
      @(posedge clk) sb <= 1'b1;
      #1 chk("spi sec", spi, 1);
      @(posedge clk) sb <= 1'b0;
      #1 x[0] = sck;
      n = 0;
      repeat (64) begin
         @(posedge clk) #1 n += (sck && !x[0]);
         x[0] = sck;
      end
      chk("susclk", n, 8);
      for (int s = 0; s < 4; s++) begin
         wreg(8'h00, 32'(s * 4 + 1));
         repeat (3) fetch(lf[1], s[1:0], 1'b1);
      end
      wreg(8'h00, 32'h3);
      wreg(8'h00, 32'h2);
      rreg(8'h00);
      chk("lock", x, 32'h3);
      boot(1'b1, 1'b0);
      rreg(8'h00);
      chk("ts kept", x[0], 1);
      @(posedge clk) rtc <= 1'b1;
      @(posedge clk) rtc <= 1'b0;
      rreg(8'h00);
      chk("ts rtc", x[0], 0);
      boot(1'b0, 1'b1);
      chk("spi hi", spi, 1);
      fetch(1'b1, 2'h0, 1'b1);
      wreg(8'h00, 32'h1);
      rreg(8'h00);
      chk("ts strap", x[0], 0);
      wreg(8'h00, 32'h50);
      @(posedge clk) pp <= 1'b1;
      @(posedge clk) pp <= 1'b0;
      repeat (100) @(posedge clk) #1;
      chk("glitch", acpi_event_interrupt, 0);
      press;
      chk("sci", acpi_event_interrupt, 1);
      wreg(8'h0c, 32'h3);
      wreg(8'h00, 32'h40);
      press;
      chk("smi", smi_n, 0);
      for (int t = 1; t < 4; t++) begin
         wreg(8'h08, 32'(t + 4));
         for (n = 0; n < 900 && ss !== 1'b0; n++) @(posedge clk) #1;
         chk("sus first", {ss, p3}, 2'h1);
         repeat (40) @(posedge clk) #1;
         chk("planes", {p3, p4, ack}, {1'b0, t == 1, t == 3});
         press;
         chk("wake", {p3, p4, ss}, 3'h7);
      end
      @(posedge clk) pp <= 1'b1;
      for (n = 0; n < 900 && ack !== 1'b1; n++) @(posedge clk) #1;
      chk("override", {ack, p4}, 2'h2);
      @(posedge clk) pp <= 1'b0;
      repeat (40) @(posedge clk);
      press;
      chk("wake s5", ack, 0);
      wreg(8'h0c, 32'h3);
      wreg(8'h00, 32'h20);
      @(posedge clk) bl <= 1'b1;
      repeat (8) @(posedge clk) #1;
      chk("batlow", smi_n, 0);
      @(posedge clk) rp <= 1'b1;
      for (n = 0; n < 900 && irst !== 1'b1; n++) @(posedge clk) #1;
      chk("rst btn", irst, 1);
      @(posedge clk) rp <= 1'b0;
      repeat (40) @(posedge clk) #1;
      chk("rst hold", {irst, prn}, 2'h2);
      for (n = 0; n < 900 && prn !== 1'b1; n++) @(posedge clk) #1;
      wreg(8'h04, 32'h2);
      for (n = 0; n < 900 && prn !== 1'b0; n++) @(posedge clk) #1;
      chk("hard rst", prn, 0);
      report_and_stop;
   end
endmodule // bps_boot_power_bench
